/* core/bwa_alu.sv */
// Behaviour
// - Add or subtract two registers, byte or word.
// - Plain subtract has no immediate form.
// - Word add/subtract uses registers only.
// - Byte add/subtract with carry or borrow.
// - Increment or decrement byte by one.
// - Word plus or minus one or two.
// - Decimal adjust byte using flags.
// - Eight by eight multiply, sixteen-bit product.
// - Sixteen by eight divide, quotient and remainder.
// - Compare updates flags, destination unchanged.
// - Word compare registers only.
// - Negate as zero minus register.
// - Bitwise AND with register or immediate.
// - Bitwise OR with register or immediate.
// - Bitwise XOR with register or immediate.
// - Invert every bit of byte.
// - Flag register holds half carry, negative, zero, overflow, carry.
//
// Chosen here: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none

module bwa_alu
  import bwa_pkg::*;
(
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  input  wire logic                       wb_cyc_i,
  input  wire logic                       wb_stb_i,
  input  wire logic                       wb_we_i,
  input  wire logic [bwa_pkg::BWA_AW-1:0] wb_adr_i,
  input  wire logic [3:0]                 wb_sel_i,
  input  wire logic [bwa_pkg::BWA_DW-1:0] wb_dat_i,
  output logic      [bwa_pkg::BWA_DW-1:0] wb_dat_o,
  output logic                            wb_ack_o
);
  import bwa_pkg::*;

  logic [BWA_DW-1:0] wmask;
  logic [BWA_DW-1:0] wdata;
  logic [BWA_DW-1:0] rd_next;
  logic              ack_reg;
  logic [BWA_DW-1:0] rd_reg;
  logic              wr_go;
  logic [15:0]       dst_reg;
  logic [15:0]       src_reg;
  logic [7:0]        imm_reg;
  logic [15:0]       res_reg;
  bwa_flags_s        flags_reg;
  bwa_op_e           op_reg;
  logic              word_reg;
  logic              use_imm_reg;
  logic              two_reg;
  logic              go_reg;
  logic              done_reg;
  logic              refused_reg;
  logic              divzero_reg;

  logic [15:0]       opb;
  bwa_arith_s        ar;
  logic [15:0]       res_next;
  bwa_flags_s        flags_next;
  logic              wr_dst;
  logic              refused;
  logic              divzero;
  logic              is_word;
  logic [7:0]        adj;
  logic              adj_c;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_lane
      assign wmask[gi*8 +: 8] = {8{wb_sel_i[gi]}};
    end
  endgenerate

  assign wdata    = wb_dat_i & wmask;
  assign wr_go    = wb_cyc_i && wb_stb_i && wb_we_i && ack_reg;
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rd_reg;

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [BWA_DW-1:0] d,
                                          input logic [BWA_DW-1:0] m);
    merge16 = (old & ~m[15:0]) | d[15:0];
  endfunction

  function automatic bwa_arith_s addsub(input logic [15:0] a, input logic [15:0] b,
                                        input logic sub, input logic cin,
                                        input logic wide);
    logic [15:0] bb;
    logic        ci;
    logic [16:0] s;
    logic [4:0]  hs;
    logic [12:0] hw;
    bwa_arith_s  r;
    bb = sub ? ~b : b;
    ci = sub ? ~cin : cin;
    s  = {1'b0, a} + {1'b0, bb} + {16'h0000, ci};
    hs = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, ci};
    hw = {1'b0, a[11:0]} + {1'b0, bb[11:0]} + {12'h000, ci};
    r.res = s[15:0];
    if (wide)
    begin
      r.c = s[16] ^ sub;
      r.v = (a[15] == bb[15]) && (s[15] != a[15]);
      r.h = hw[12] ^ sub;
    end
    else
    begin
      r.c = (a[8] ^ bb[8] ^ s[8]) ^ sub;
      r.v = (a[7] == bb[7]) && (s[7] != a[7]);
      r.h = hs[4] ^ sub;
    end
    addsub = r;
  endfunction

  // Wishbone classic slave: one ack per request, answered one cycle after it.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_reg <= 1'b0;
    else
      ack_reg <= wb_cyc_i && wb_stb_i && !ack_reg;
  end

  always_comb
  begin
    rd_next = '0;
    case (wb_adr_i)
      BWA_OFF_CTRL:
      begin
        rd_next[BWA_CTRL_OP_LSB +: BWA_CTRL_OP_W] = op_reg;
        rd_next[BWA_CTRL_WORD] = word_reg;
        rd_next[BWA_CTRL_IMM]  = use_imm_reg;
        rd_next[BWA_CTRL_TWO]  = two_reg;
      end
      BWA_OFF_DST:   rd_next[15:0] = dst_reg;
      BWA_OFF_SRC:   rd_next[15:0] = src_reg;
      BWA_OFF_IMM:   rd_next[7:0]  = imm_reg;
      BWA_OFF_RES:   rd_next[15:0] = res_reg;
      BWA_OFF_FLAGS: rd_next[4:0]  = flags_reg;
      BWA_OFF_STAT:
      begin
        rd_next[BWA_STAT_DONE]    = done_reg;
        rd_next[BWA_STAT_REFUSED] = refused_reg;
        rd_next[BWA_STAT_DIVZERO] = divzero_reg;
      end
      default:       rd_next = '0;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rd_reg <= '0;
    else if (wb_cyc_i && wb_stb_i && !ack_reg)
      rd_reg <= rd_next;
  end

  // Control register: a write with the go bit set launches one operation.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      op_reg      <= OP_ADD;
      word_reg    <= 1'b0;
      use_imm_reg <= 1'b0;
      two_reg     <= 1'b0;
      go_reg      <= 1'b0;
    end
    else
    begin
      go_reg <= 1'b0;
      if (wr_go && wb_adr_i == BWA_OFF_CTRL)
      begin
        if (wb_sel_i[0])
          op_reg <= bwa_op_e'(wb_dat_i[BWA_CTRL_OP_LSB +: BWA_CTRL_OP_W]);
        if (wb_sel_i[1])
        begin
          word_reg    <= wb_dat_i[BWA_CTRL_WORD];
          use_imm_reg <= wb_dat_i[BWA_CTRL_IMM];
          two_reg     <= wb_dat_i[BWA_CTRL_TWO];
        end
        go_reg <= wb_sel_i[3] && wb_dat_i[BWA_CTRL_GO];
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      src_reg <= BWA_SRC_RST;
      imm_reg <= BWA_IMM_RST;
    end
    else if (wr_go && wb_adr_i == BWA_OFF_SRC)
      src_reg <= merge16(src_reg, wdata, wmask);
    else if (wr_go && wb_adr_i == BWA_OFF_IMM)
      imm_reg <= (imm_reg & ~wmask[7:0]) | wdata[7:0];
  end

  // Datapath.
  always_comb
  begin
    opb        = use_imm_reg ? {8'h00, imm_reg} : src_reg;
    is_word    = 1'b0;
    ar         = addsub(dst_reg, opb, 1'b0, 1'b0, 1'b0);
    res_next   = dst_reg;
    flags_next = flags_reg;
    wr_dst     = 1'b1;
    refused    = 1'b0;
    divzero    = 1'b0;
    adj        = 8'h00;
    adj_c      = flags_reg.c;
    case (op_reg)
      OP_ADD, OP_SUB, OP_COMPARE_OPERATION:
      begin
        is_word = word_reg;
        ar = addsub(dst_reg, opb, op_reg != OP_ADD, 1'b0, word_reg);
        res_next = word_reg ? ar.res : {dst_reg[15:8], ar.res[7:0]};
        refused = (op_reg == OP_SUB && use_imm_reg)
               || (word_reg && use_imm_reg);
        wr_dst = (op_reg != OP_COMPARE_OPERATION);
      end
      OP_ADD_WITH_CARRY, OP_SUBTRACT_WITH_BORROW:
      begin
        ar = addsub(dst_reg, opb, op_reg == OP_SUBTRACT_WITH_BORROW,
                    flags_reg.c, 1'b0);
        res_next = {dst_reg[15:8], ar.res[7:0]};
      end
      OP_INCREMENT, OP_DECREMENT_BY_ONE:
      begin
        ar = addsub(dst_reg, 16'h0001, op_reg == OP_DECREMENT_BY_ONE,
                    1'b0, 1'b0);
        res_next = {dst_reg[15:8], ar.res[7:0]};
      end
      OP_WORD_PLUS_SMALL, OP_WORD_MINUS_SMALL:
      begin
        is_word = 1'b1;
        ar = addsub(dst_reg, two_reg ? 16'h0002 : 16'h0001,
                    op_reg == OP_WORD_MINUS_SMALL, 1'b0, 1'b1);
        res_next = ar.res;
      end
      OP_DECIMAL_ADJUST_AFTER_ADD, OP_DECIMAL_ADJUST_AFTER_SUBTRACT:
      begin
        if (op_reg == OP_DECIMAL_ADJUST_AFTER_ADD)
        begin
          if (flags_reg.h || dst_reg[3:0] > BWA_BCD_LIMIT)
            adj = adj | BWA_BCD_LO;
          if (flags_reg.c || dst_reg[7:0] > BWA_BCD_MAX)
          begin
            adj   = adj | BWA_BCD_HI;
            adj_c = 1'b1;
          end
          res_next = {dst_reg[15:8], dst_reg[7:0] + adj};
        end
        else
        begin
          if (flags_reg.h)
            adj = adj | BWA_BCD_LO;
          if (flags_reg.c)
            adj = adj | BWA_BCD_HI;
          res_next = {dst_reg[15:8], dst_reg[7:0] - adj};
        end
      end
      OP_UNSIGNED_MULTIPLY:
      begin
        is_word = 1'b1;
        res_next = {8'h00, dst_reg[7:0]} * {8'h00, src_reg[7:0]};
      end
      OP_UNSIGNED_DIVIDE:
      begin
        divzero = (src_reg[7:0] == 8'h00);
        wr_dst = !divzero;
        if (!divzero)
        begin
          res_next[7:0]  = 8'(dst_reg / {8'h00, src_reg[7:0]});
          res_next[15:8] = 8'(dst_reg % {8'h00, src_reg[7:0]});
        end
      end
      OP_TWOS_COMPLEMENT_NEGATE:
      begin
        ar = addsub(16'h0000, dst_reg, 1'b1, 1'b0, 1'b0);
        res_next = {dst_reg[15:8], ar.res[7:0]};
      end
      OP_AND: res_next = {dst_reg[15:8], dst_reg[7:0] & opb[7:0]};
      OP_OR:  res_next = {dst_reg[15:8], dst_reg[7:0] | opb[7:0]};
      OP_XOR: res_next = {dst_reg[15:8], dst_reg[7:0] ^ opb[7:0]};
      OP_NOT: res_next = {dst_reg[15:8], ~dst_reg[7:0]};
      default: refused = 1'b1;
    endcase
    // Flag update by operation class.
    case (op_reg)
      OP_ADD, OP_SUB, OP_COMPARE_OPERATION, OP_ADD_WITH_CARRY,
      OP_SUBTRACT_WITH_BORROW, OP_TWOS_COMPLEMENT_NEGATE,
      OP_WORD_PLUS_SMALL, OP_WORD_MINUS_SMALL:
      begin
        flags_next.n = is_word ? res_next[15] : res_next[7];
        flags_next.z = is_word ? (res_next == 16'h0000) : (res_next[7:0] == 8'h00);
        flags_next.v = ar.v;
        flags_next.c = ar.c;
        flags_next.h = ar.h;
        if (op_reg == OP_ADD_WITH_CARRY || op_reg == OP_SUBTRACT_WITH_BORROW)
          flags_next.z = flags_reg.z && (res_next[7:0] == 8'h00);
      end
      OP_INCREMENT, OP_DECREMENT_BY_ONE:
      begin
        flags_next.n = res_next[7];
        flags_next.z = (res_next[7:0] == 8'h00);
        flags_next.v = ar.v;
      end
      OP_DECIMAL_ADJUST_AFTER_ADD, OP_DECIMAL_ADJUST_AFTER_SUBTRACT:
      begin
        flags_next.n = res_next[7];
        flags_next.z = (res_next[7:0] == 8'h00);
        flags_next.c = adj_c;
      end
      OP_UNSIGNED_DIVIDE:
      begin
        flags_next.n = !divzero && res_next[7];
        flags_next.z = divzero;
      end
      OP_AND, OP_OR, OP_XOR, OP_NOT:
      begin
        flags_next.n = res_next[7];
        flags_next.z = (res_next[7:0] == 8'h00);
        flags_next.v = 1'b0;
      end
      default: flags_next = flags_reg;
    endcase
  end

  // Execution: destination, result and flags follow one cycle after go.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dst_reg   <= BWA_DST_RST;
      res_reg   <= '0;
      flags_reg <= '0;
    end
    else if (go_reg)
    begin
      if (!refused)
      begin
        res_reg   <= res_next;
        flags_reg <= flags_next;
        if (wr_dst)
          dst_reg <= res_next;
      end
    end
    else if (wr_go && wb_adr_i == BWA_OFF_DST)
      dst_reg <= merge16(dst_reg, wdata, wmask);
    else if (wr_go && wb_adr_i == BWA_OFF_FLAGS && wb_sel_i[0])
      flags_reg <= wb_dat_i[4:0];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      done_reg    <= 1'b0;
      refused_reg <= 1'b0;
      divzero_reg <= 1'b0;
    end
    else if (go_reg)
    begin
      done_reg    <= 1'b1;
      refused_reg <= refused;
      divzero_reg <= divzero && !refused;
    end
    else if (wr_go && wb_adr_i == BWA_OFF_CTRL)
      done_reg <= 1'b0;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_add_byte_result: assert property (go_reg && op_reg == OP_ADD && !word_reg
    |=> dst_reg[7:0] == 8'($past(dst_reg[7:0]) + $past(opb[7:0])))
    else $error("byte add result wrong");
  a_sub_imm_refused: assert property (go_reg && op_reg == OP_SUB && use_imm_reg
    |=> refused_reg && $stable(dst_reg))
    else $error("immediate subtract not refused");
  a_word_imm_refused: assert property (go_reg && word_reg && use_imm_reg
    && (op_reg == OP_ADD || op_reg == OP_COMPARE_OPERATION) |=> refused_reg)
    else $error("word immediate not refused");
  a_carry_add_in: assert property (go_reg && op_reg == OP_ADD_WITH_CARRY
    |=> dst_reg[7:0] == 8'($past(dst_reg[7:0]) + $past(opb[7:0]) + {7'h00, $past(flags_reg.c)}))
    else $error("carry add result wrong");
  a_inc_by_one: assert property (go_reg && op_reg == OP_INCREMENT
    |=> dst_reg[7:0] == 8'($past(dst_reg[7:0]) + 8'h01))
    else $error("increment wrong");
  a_word_small_step: assert property (go_reg && op_reg == OP_WORD_MINUS_SMALL
    |=> dst_reg == 16'($past(dst_reg) - ($past(two_reg) ? 16'h0002 : 16'h0001)))
    else $error("word small subtract wrong");
  a_mul_product: assert property (go_reg && op_reg == OP_UNSIGNED_MULTIPLY
    |=> dst_reg == $past(dst_reg[7:0]) * $past(src_reg[7:0]))
    else $error("product wrong");
  a_div_pair: assert property (go_reg && op_reg == OP_UNSIGNED_DIVIDE
    && src_reg[7:0] != 8'h00
    |=> dst_reg[7:0] * $past(src_reg[7:0]) + dst_reg[15:8] == $past(dst_reg))
    else $error("quotient and remainder wrong");
  a_compare_keeps: assert property (go_reg && op_reg == OP_COMPARE_OPERATION
    ##1 !go_reg |-> $stable(dst_reg))
    else $error("compare changed destination");
  a_negate_zero: assert property (go_reg && op_reg == OP_TWOS_COMPLEMENT_NEGATE
    |=> dst_reg[7:0] == 8'(8'h00 - $past(dst_reg[7:0])))
    else $error("negate wrong");
  a_logic_flags: assert property (go_reg && (op_reg == OP_AND || op_reg == OP_XOR)
    |=> !flags_reg.v && flags_reg.c == $past(flags_reg.c) && flags_reg.n == dst_reg[7])
    else $error("logic flags wrong");
  a_zero_flag: assert property (go_reg && op_reg == OP_SUB && !use_imm_reg
    |=> flags_reg.z == (word_reg ? res_reg == 16'h0000 : res_reg[7:0] == 8'h00))
    else $error("zero flag wrong");
  a_bus_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");

  c_divide_zero: cover property (go_reg && op_reg == OP_UNSIGNED_DIVIDE && src_reg[7:0] == 8'h00);
  c_decimal_add: cover property (go_reg && op_reg == OP_DECIMAL_ADJUST_AFTER_ADD && flags_reg.h);
  c_word_compare: cover property (go_reg && op_reg == OP_COMPARE_OPERATION && word_reg);
  c_borrow_chain: cover property (go_reg && op_reg == OP_SUBTRACT_WITH_BORROW && flags_reg.c);

endmodule

`default_nettype wire

/* core/bwa_pkg.sv */
package bwa_pkg;

  localparam int unsigned BWA_DW = 32;
  localparam int unsigned BWA_AW = 8;

  localparam logic [7:0] BWA_OFF_CTRL  = 8'h00;
  localparam logic [7:0] BWA_OFF_DST   = 8'h04;
  localparam logic [7:0] BWA_OFF_SRC   = 8'h08;
  localparam logic [7:0] BWA_OFF_IMM   = 8'h0c;
  localparam logic [7:0] BWA_OFF_RES   = 8'h10;
  localparam logic [7:0] BWA_OFF_FLAGS = 8'h14;
  localparam logic [7:0] BWA_OFF_STAT  = 8'h18;

  localparam int unsigned BWA_CTRL_OP_LSB  = 0;
  localparam int unsigned BWA_CTRL_OP_W    = 5;
  localparam int unsigned BWA_CTRL_WORD    = 8;
  localparam int unsigned BWA_CTRL_IMM     = 9;
  localparam int unsigned BWA_CTRL_TWO     = 10;
  localparam int unsigned BWA_CTRL_GO      = 31;
  localparam int unsigned BWA_STAT_DONE    = 0;
  localparam int unsigned BWA_STAT_REFUSED = 1;
  localparam int unsigned BWA_STAT_DIVZERO = 2;

  localparam logic [15:0] BWA_DST_RST   = 16'h0000;
  localparam logic [15:0] BWA_SRC_RST   = 16'h0000;
  localparam logic [7:0]  BWA_IMM_RST   = 8'h00;
  localparam logic [3:0]  BWA_BCD_LIMIT = 4'h9;
  localparam logic [7:0]  BWA_BCD_LO    = 8'h06;
  localparam logic [7:0]  BWA_BCD_HI    = 8'h60;
  localparam logic [7:0]  BWA_BCD_MAX   = 8'h99;

  typedef enum logic [4:0] {
    OP_ADD       = 5'h00,
    OP_SUB       = 5'h01,
    OP_ADD_WITH_CARRY        = 5'h02,
    OP_SUBTRACT_WITH_BORROW  = 5'h03,
    OP_INCREMENT             = 5'h04,
    OP_DECREMENT_BY_ONE      = 5'h05,
    OP_WORD_PLUS_SMALL       = 5'h06,
    OP_WORD_MINUS_SMALL      = 5'h07,
    OP_DECIMAL_ADJUST_AFTER_ADD      = 5'h08,
    OP_DECIMAL_ADJUST_AFTER_SUBTRACT = 5'h09,
    OP_UNSIGNED_MULTIPLY     = 5'h0a,
    OP_UNSIGNED_DIVIDE       = 5'h0b,
    OP_COMPARE_OPERATION     = 5'h0c,
    OP_TWOS_COMPLEMENT_NEGATE = 5'h0d,
    OP_AND       = 5'h0e,
    OP_OR        = 5'h0f,
    OP_XOR       = 5'h10,
    OP_NOT       = 5'h11
  } bwa_op_e;

  typedef struct packed {
    logic h;
    logic n;
    logic z;
    logic v;
    logic c;
  } bwa_flags_s;

  typedef struct packed {
    logic [15:0] res;
    logic        c;
    logic        v;
    logic        h;
  } bwa_arith_s;

endpackage

/* sim/bwa_wb_host.sv */
`timescale 1ns/1ps
`default_nettype none

module bwa_wb_host
  import bwa_pkg::*;
(
  input  wire logic                       clk_i,
  output logic                            cyc_o,
  output logic                            stb_o,
  output logic                            we_o,
  output logic      [bwa_pkg::BWA_AW-1:0] adr_o,
  output logic      [3:0]                 sel_o,
  output logic      [bwa_pkg::BWA_DW-1:0] dat_o,
  input  wire logic                       ack_i,
  input  wire logic [bwa_pkg::BWA_DW-1:0] dat_i
);
  initial
  begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o  = 1'b0;
    adr_o = '0;
    sel_o = 4'h0;
    dat_o = '0;
  end

  // One classic cycle; the released address and data are inverted so stale values never match.
  task automatic access(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                        input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o  <= we;
    adr_o <= adr;
    sel_o <= sel;
    dat_o <= wd;
    do
      @(posedge clk_i);
    while (ack_i !== 1'b1);
    rd = dat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    adr_o <= ~adr;
    dat_o <= ~wd;
  endtask
endmodule

`default_nettype wire

/* sim/bwa_alu_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module bwa_alu_tb_top;
  import bwa_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wb_cyc, wb_stb, wb_we, wb_ack;
  logic [7:0]  wb_adr;
  logic [3:0]  wb_sel;
  logic [31:0] wb_wdat, wb_rdat, mon_e, mon_m, lst_e, lst_m;
  logic [31:0] exp_q[$], msk_q[$];
  string       name_q[$];
  int          miscompares = 0, checked = 0, cycles = 0;
  integer      seed = 32'hf9ca;
  logic [4:0]  t_op, t_f;
  logic [15:0] t_d, t_s, t_res = 16'h0000;
  logic [7:0]  t_i;
  logic        t_w, t_im, t_two;

  always #2 clk_i = ~clk_i;

  bwa_alu u_bwa_alu (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
    .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack));

  bwa_wb_host u_bwa_wb_host (.clk_i(clk_i), .cyc_o(wb_cyc), .stb_o(wb_stb), .we_o(wb_we),
    .adr_o(wb_adr), .sel_o(wb_sel), .dat_o(wb_wdat), .ack_i(wb_ack), .dat_i(wb_rdat));

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 10000)
    begin
      miscompares++;
      complete_run();
    end
  end

  // Each read answer is compared with the oldest noted expectation.
  always @(posedge clk_i)
    if (wb_cyc === 1'b1 && wb_stb === 1'b1 && wb_we === 1'b0 && wb_ack === 1'b1)
    begin
      if (name_q.size() == 0)
        miscompares++;
      else
      begin
        mon_e = exp_q.pop_front();
        mon_m = msk_q.pop_front();
        check(name_q.pop_front(), wb_rdat & mon_m, mon_e & mon_m);
      end
    end

  task automatic wr(logic [7:0] a, logic [3:0] s, logic [31:0] d);
    logic [31:0] r;
    u_bwa_wb_host.access(1'b1, a, s, d, r);
  endtask

  task automatic rd(string nm, logic [7:0] a, logic [31:0] e, logic [31:0] m);
    logic [31:0] r;
    name_q.push_back(nm);
    exp_q.push_back(e);
    msk_q.push_back(m);
    u_bwa_wb_host.access(1'b0, a, 4'hf, 32'h0, r);
  endtask

  function automatic void ref_op(input logic [4:0] op, input logic w, im, two,
    input logic [15:0] d, s, input logic [7:0] iv, input logic [4:0] f,
    output logic [15:0] rd_o, rs_o, output logic [4:0] rf, fm, output logic [2:0] st, sm);
    logic [15:0] x, y;
    logic [16:0] r;
    logic [7:0]  b, lr;
    logic        sub, ci, ww, ar, zk, ck, xm, ym, rm;
    b = im ? iv : s[7:0];
    rd_o = d;
    rf = f;
    fm = 5'h0f;
    st = 3'b001;
    sm = 3'b111;
    {ww, sub, ci, ar, zk, ck} = 6'b000100;
    x = {8'h00, d[7:0]};
    y = {8'h00, b};
    lr = 8'h00;
    case (op)
      OP_ADD, OP_SUB, OP_COMPARE_OPERATION:
      begin
        ww = w;
        sub = (op != OP_ADD);
        if (w)
          y = s;
      end
      OP_ADD_WITH_CARRY, OP_SUBTRACT_WITH_BORROW:
      begin
        sub = op[0];
        ci = f[0];
        zk = 1'b1;
      end
      OP_INCREMENT, OP_DECREMENT_BY_ONE:
      begin
        sub = op[0];
        y = 16'h0001;
        ck = 1'b1;
      end
      OP_WORD_PLUS_SMALL, OP_WORD_MINUS_SMALL:
      begin
        ww = 1'b1;
        sub = op[0];
        y = two ? 16'h0002 : 16'h0001;
      end
      OP_TWOS_COMPLEMENT_NEGATE:
      begin
        sub = 1'b1;
        x = 16'h0000;
        y = {8'h00, d[7:0]};
      end
      default: ar = 1'b0;
    endcase
    if (ww && op != OP_TWOS_COMPLEMENT_NEGATE)
      x = d;
    if (ar)
    begin
      r = sub ? {1'b0, x} - {1'b0, y} - 17'(ci) : {1'b0, x} + {1'b0, y} + 17'(ci);
      xm = ww ? x[15] : x[7];
      ym = ww ? y[15] : y[7];
      rm = ww ? r[15] : r[7];
      rf[3] = rm;
      rf[2] = (ww ? r[15:0] == 16'h0000 : r[7:0] == 8'h00) && (!zk || f[2]);
      rf[1] = sub ? (xm != ym) && (rm != xm) : (xm == ym) && (rm != xm);
      if (!ck)
        rf[0] = ww ? r[16] : r[8];
      rs_o = ww ? r[15:0] : {d[15:8], r[7:0]};
      if (op != OP_COMPARE_OPERATION)
        rd_o = rs_o;
    end
    case (op)
      OP_UNSIGNED_MULTIPLY: rd_o = 16'(d[7:0]) * 16'(s[7:0]);
      OP_UNSIGNED_DIVIDE:
        if (s[7:0] == 8'h00)
        begin
          rf[3:2] = 2'b01;
          fm = 5'h0c;
          st = 3'b101;
        end
        else
        begin
          rd_o = {8'(d % s[7:0]), 8'(d / s[7:0])};
          fm = 5'h00;
        end
      OP_DECIMAL_ADJUST_AFTER_ADD:
      begin
        rd_o[7:0] = d[7:0] + ((f[4] || d[3:0] > 4'h9) ? 8'h06 : 8'h00)
                    + ((f[0] || d[7:0] > 8'h99) ? 8'h60 : 8'h00);
        rf[0] = f[0] | (d[7:0] > 8'h99);
        fm = 5'h01;
      end
      OP_DECIMAL_ADJUST_AFTER_SUBTRACT:
      begin
        rd_o[7:0] = d[7:0] - (f[4] ? 8'h06 : 8'h00) - (f[0] ? 8'h60 : 8'h00);
        fm = 5'h01;
      end
      OP_AND, OP_OR, OP_XOR, OP_NOT:
      begin
        lr = (op == OP_AND) ? d[7:0] & b : (op == OP_OR) ? d[7:0] | b :
             (op == OP_XOR) ? d[7:0] ^ b : ~d[7:0];
        rd_o[7:0] = lr;
        rf[3:1] = {lr[7], lr == 8'h00, 1'b0};
      end
      default: ;
    endcase
    if (op != OP_COMPARE_OPERATION)
      rs_o = rd_o;
    if ((op == OP_SUB && im) || (w && im && (op == OP_ADD || op == OP_SUB ||
        op == OP_COMPARE_OPERATION)) || op > 5'h11)
    begin
      rd_o = d;
      rf = f;
      fm = 5'h0f;
      st = 3'b010;
      sm = 3'b110;
    end
  endfunction

  task automatic run_op(logic [4:0] op, logic w, im, two, logic [15:0] d, s,
                        logic [7:0] iv, logic [4:0] f);
    logic [15:0] ed, er;
    logic [4:0]  ef, fm;
    logic [2:0]  es, sm;
    wr(BWA_OFF_DST, 4'h3, {16'h0000, d});
    wr(BWA_OFF_SRC, 4'h3, {16'h0000, s});
    wr(BWA_OFF_IMM, 4'h1, {24'h000000, iv});
    wr(BWA_OFF_FLAGS, 4'h1, {27'h0, f});
    wr(BWA_OFF_CTRL, 4'hf, {1'b1, 20'h0, two, im, w, 3'h0, op});
    ref_op(op, w, im, two, d, s, iv, f, ed, er, ef, fm, es, sm);
    rd("ctrl go", BWA_OFF_CTRL, 32'h0, 32'h8000_0000);
    rd("dst", BWA_OFF_DST, {16'h0000, ed}, 32'h0000_ffff);
    rd("flags", BWA_OFF_FLAGS, {27'h0, ef}, {27'h0, fm});
    rd("stat", BWA_OFF_STAT, {29'h0, es}, {29'h0, sm});
    if (!es[1])
      t_res = er;
    rd("res", BWA_OFF_RES, {16'h0000, t_res}, 32'h0000_ffff);
    lst_e = {29'h0, es};
    lst_m = {29'h0, sm};
  endtask

  initial
  begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int a = 0; a <= 28; a += 4)
      rd("reset value", 8'(a), 32'h0, 32'hffff_ffff);
    for (int k = 0; k < 160; k++)
    begin
      t_op = (k % 20 < 18) ? 5'(k % 20) : ((k % 20 == 18) ? 5'h12 : 5'h1f);
      {t_d, t_s} = $random(seed);
      {t_i, t_f, t_w, t_im, t_two} = 16'($random(seed));
      t_im = t_im && (t_op < 5'h04 || t_op == 5'h0c || (t_op >= 5'h0e && t_op <= 5'h10));
      if (k % 3 == 0)
        t_d[7:0] = 8'h7f + 8'(k[3]);
      if (k % 40 == 11)
        t_s[7:0] = 8'h00;
      if (t_op == OP_UNSIGNED_DIVIDE && t_s[7:0] != 8'h00)
        t_d[15:8] = t_d[15:8] % t_s[7:0];
      run_op(t_op, t_w, t_im, t_two, t_d, t_s, t_i, t_f);
    end
    wr(BWA_OFF_STAT, 4'hf, 32'hffff_ffff);
    rd("stat read only", BWA_OFF_STAT, lst_e, lst_m);
    wr(BWA_OFF_RES, 4'hf, 32'hffff_ffff);
    rd("res read only", BWA_OFF_RES, {16'h0000, t_res}, 32'hffff_ffff);
    wr(8'h1c, 4'hf, 32'hffff_ffff);
    rd("unmapped", 8'h1c, 32'h0, 32'hffff_ffff);
    complete_run();
  end
endmodule

`default_nettype wire
